// ---- core/brs_defs.vh ----
`ifndef BRS_DEFS_VH
`define BRS_DEFS_VH

// ==========================================================
// Boot addresses
`define BRS_RESET_VADDR     32'hA000_0000
`define BRS_SEG_MASK        32'hE000_0000
`define BRS_SEG_BASE        32'hA000_0000
`define BRS_PHYS_MASK       32'h1FFF_FFFF
`define BRS_BOOT_PADDR      32'h0000_0000
`define BRS_CS_SIZE_MASK    32'hFC00_0000

// ==========================================================
// Timing
`define BRS_CLK_MHZ         20
`define BRS_OSC_SETTLE_US   1000
`define BRS_OSC_SETTLE_CYC  (`BRS_OSC_SETTLE_US * `BRS_CLK_MHZ)
`define BRS_SYNC_STAGES     2

// ==========================================================
// Clock control reset values
`define BRS_PLL_EN_RST      2'b00
`define BRS_DIV_RST         4'h0
`define BRS_GATE_RST        8'hFF

`endif

// ---- core/brs_sequencer.v ----
`timescale 1ns/10ps
`include "brs_defs.vh"

// Functional notes
// - Whole logic held in reset while supply detector reports low supply.
// - After supply reset the system clock comes from the primary clock input.
// - Oscillator select strap level decides crystal versus external clock.
// - With crystal, reset extends until oscillator settling reports stable.
// - With external clock, reset releases with no settling delay.
// - All PLLs disabled at start-up until software enables them.
// - After reset all module clocks run ungated and undivided.
// - First fetch after release is at virtual address 0xA000_0000.
// - Fixed segment bypasses translation and cache, maps onto 0 to 0x1FFF_FFFF.
// - Physical address zero decodes to boot chip select on external memory.
// - Software may later enable PLLs, set dividers and gate clocks.
module brs_sequencer #(
   parameter SETTLE_CYC = `BRS_OSC_SETTLE_CYC
) (
   // Clock and supply reset
   input  wire        clk,
   input  wire        nrst,
   // Board strap and oscillator status
   input  wire        oscillator_select_strap,
   input  wire        osc_stable,
   // Software clock control requests
   input  wire        cfg_we,
   input  wire [1:0]  cfg_pll_en,
   input  wire [3:0]  cfg_div,
   input  wire [7:0]  cfg_gate,
   // Processor fetch address in
   input  wire [31:0] cpu_vaddr,
   input  wire        cpu_req,
   // Reset and clock outputs
   output wire        sys_nrst,
   output reg         crystal_mode,
   output reg  [1:0]  pll_en,
   output reg  [3:0]  clk_div,
   output reg  [7:0]  clk_gate,
   output wire        clk_source_primary,
   // Fetch and decode outputs
   output reg  [31:0] fetch_vaddr,
   output reg  [31:0] phys_addr,
   output reg         uncached,
   output reg         untranslated,
   output reg         boot_chip_select,
   output reg         mem_req
);

   // ==========================================================
   // Sequencer states
   localparam ST_STRAP  = 2'b00;
   localparam ST_SETTLE = 2'b01;
   localparam ST_SYNC   = 2'b10;
   localparam ST_RUN    = 2'b11;

   reg [1:0]  state;
   reg [1:0]  next_state;
   reg [31:0] settle_cnt;
   reg [1:0]  rel_sync;
   reg        first_fetch;

   wire       seg_hit;
   wire [31:0] xlat;
   wire       release_ok;

   // Clock is always the primary clock input pin
   assign clk_source_primary = 1'b1;

   // ==========================================================
   // State machine: strap sampled after supply release
   always @* begin
      next_state = state;
      case (state)
         ST_STRAP: begin
            // Decide from the pin itself, the strap flop is still loading
            next_state = oscillator_select_strap ? ST_SYNC : ST_SETTLE;
         end
         ST_SETTLE: begin
            if (osc_stable && settle_cnt == 32'h0000_0000)
               next_state = ST_SYNC;
         end
         ST_SYNC: begin
            next_state = ST_RUN;
         end
         ST_RUN: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_STRAP;
         end
      endcase
   end

   // Strap captured by clocked process after release
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state        <= ST_STRAP;
         crystal_mode <= 1'b0;
         settle_cnt   <= 32'h0000_0000;
      end else begin
         state <= next_state;
         if (state == ST_STRAP) begin
            crystal_mode <= ~oscillator_select_strap;
            settle_cnt   <= SETTLE_CYC;
         end else if (state == ST_SETTLE && settle_cnt != 32'h0000_0000) begin
            settle_cnt <= settle_cnt - 32'h0000_0001;
         end
      end
   end

   // Release requested once the state machine reaches ST_RUN
   assign release_ok = (state == ST_RUN);

   // ==========================================================
   // Reset synchroniser: async assert, sync release
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rel_sync <= 2'b00;
      end else begin
         rel_sync <= {rel_sync[0], release_ok};
      end
   end

   assign sys_nrst = rel_sync[1];

   // ==========================================================
   // Clock control: PLLs off, clocks undivided and running
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pll_en   <= `BRS_PLL_EN_RST;
         clk_div  <= `BRS_DIV_RST;
         clk_gate <= `BRS_GATE_RST;
      end else if (!sys_nrst) begin
         pll_en   <= `BRS_PLL_EN_RST;
         clk_div  <= `BRS_DIV_RST;
         clk_gate <= `BRS_GATE_RST;
      end else if (cfg_we) begin
         pll_en   <= cfg_pll_en;
         clk_div  <= cfg_div;
         clk_gate <= cfg_gate;
      end
   end

   // ==========================================================
   // Fixed segment decode
   assign seg_hit = ((fetch_vaddr & `BRS_SEG_MASK) == `BRS_SEG_BASE);
   assign xlat    = fetch_vaddr & `BRS_PHYS_MASK;

   // Fetch address: reset vector first, then processor requests
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fetch_vaddr <= `BRS_RESET_VADDR;
         first_fetch <= 1'b1;
         mem_req     <= 1'b0;
      end else if (!sys_nrst) begin
         fetch_vaddr <= `BRS_RESET_VADDR;
         first_fetch <= 1'b1;
         mem_req     <= 1'b0;
      end else if (first_fetch) begin
         fetch_vaddr <= `BRS_RESET_VADDR;
         first_fetch <= 1'b0;
         mem_req     <= 1'b1;
      end else begin
         mem_req <= cpu_req;
         if (cpu_req)
            fetch_vaddr <= cpu_vaddr;
      end
   end

   // Physical address and chip select registered from decode
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phys_addr        <= `BRS_BOOT_PADDR;
         uncached         <= 1'b1;
         untranslated     <= 1'b1;
         boot_chip_select <= 1'b0;
      end else begin
         phys_addr    <= seg_hit ? xlat : fetch_vaddr;
         uncached     <= seg_hit;
         untranslated <= seg_hit;
         // Boot chip select window begins at physical zero
         boot_chip_select <= seg_hit && sys_nrst &&
                             ((xlat & `BRS_CS_SIZE_MASK) == `BRS_BOOT_PADDR);
      end
   end

endmodule // brs_sequencer

// ---- verif/brs_checker.sv ----
`timescale 1ns/10ps
// ====
// Port checker
module brs_checker (
   // Clock, reset, strap
   input wire        clk, nrst, oscillator_select_strap, osc_stable,
   // Clock settings in
   input wire        cfg_we,
   input wire [1:0]  cfg_pll_en,
   input wire [3:0]  cfg_div,
   input wire [7:0]  cfg_gate,
   // Outputs
   input wire        sys_nrst, crystal_mode, clk_source_primary, mem_req,
   input wire        uncached, untranslated, boot_chip_select,
   input wire [1:0]  pll_en,
   input wire [3:0]  clk_div,
   input wire [7:0]  clk_gate,
   input wire [31:0] fetch_vaddr, phys_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_reset_holds: assert property (disable iff (1'b0) !nrst |-> !sys_nrst)
      else $error("system reset not held");
   a_sync_release: assert property ($rose(sys_nrst) |-> $past(nrst, 4))
      else $error("release too early");
   a_ext_quick: assert property ($rose(nrst) && oscillator_select_strap
      |-> ##[1:8] sys_nrst) else $error("external clock release late");
   a_xtal_wait: assert property (!sys_nrst && crystal_mode && !osc_stable
      |=> !sys_nrst) else $error("released before settling");
   a_strap_read: assert property (sys_nrst
      |-> crystal_mode == !oscillator_select_strap) else $error("strap misread");
   a_clk_default: assert property (!sys_nrst |-> pll_en == 2'b00
      && clk_div == 4'h0 && clk_gate == 8'hFF && clk_source_primary)
      else $error("clock defaults wrong");
   a_boot_fetch: assert property ($rose(sys_nrst) |-> ##[1:2] mem_req
      && fetch_vaddr == 32'hA000_0000) else $error("boot fetch wrong");
   a_seg_map: assert property (mem_req && fetch_vaddr[31:29] == 3'b101
      |=> phys_addr == ($past(fetch_vaddr) & 32'h1FFF_FFFF) && uncached
      && untranslated) else $error("segment map wrong");
   a_boot_cs: assert property (mem_req && fetch_vaddr[31:26] == 6'h28
      |=> boot_chip_select) else $error("boot select missing");
   a_cfg_load: assert property (sys_nrst && cfg_we |=> {pll_en, clk_div,
      clk_gate} == {$past(cfg_pll_en), $past(cfg_div), $past(cfg_gate)})
      else $error("clock settings not loaded");
endmodule // brs_checker

// ---- verif/brs_osc_model.sv ----
`timescale 1ns/10ps
// ====
// Clock source: a crystal settles late, an external clock gives no flag
module brs_osc_model #(parameter DLY = 10) (
   input  wire clk,
   input  wire oscillator_select_strap,
   output reg  osc_stable = 1'b0
);
   integer cnt = 0;
   // Settling count runs only with a crystal fitted
   always @(posedge clk) begin
      cnt <= oscillator_select_strap ? 0 : cnt + 1;
      osc_stable <= !oscillator_select_strap && cnt >= DLY;
   end
endmodule // brs_osc_model

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
// ====
// Boot sequencer bench
module testbench;
   reg clk = 0, nrst = 1, oscillator_select_strap = 1, cfg_we = 0, cpu_req = 0;
   reg        last_v = 0;
   reg [31:0] last_va = 0;
   reg [1:0]  cfg_pll_en = 0;
   reg [3:0]  cfg_div = 0;
   reg [7:0]  cfg_gate = 0;
   reg [31:0] cpu_vaddr = 0, r = 32'hb86c;
   wire osc_stable, sys_nrst, crystal_mode, clk_source_primary, uncached;
   wire untranslated, boot_chip_select, mem_req;
   wire [1:0]  pll_en;
   wire [3:0]  clk_div;
   wire [7:0]  clk_gate;
   wire [31:0] fetch_vaddr, phys_addr;
   reg [31:0] q[$];
   integer n_fail = 0, checks = 0, i, k;
   always #25 clk = ~clk;
   brs_osc_model brs_osc_model_i (.*);
   brs_sequencer #(.SETTLE_CYC(4)) brs_sequencer_i (.*);
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task tick; begin @(posedge clk); #1; end endtask
   task chk(input [31:0] seen, input [31:0] exp); begin
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t saw %h want %h", $time, seen, exp);
      end
   end endtask
   task report_and_stop; begin
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   end endtask
   // Reset with strap s, settings offered during reset must be refused
   task boot(input s); begin
      nrst = 0; oscillator_select_strap = s; r = lfsr(r);
      cfg_we = 1; {cfg_pll_en, cfg_div, cfg_gate} = r[13:0];
      repeat (3) tick;
      nrst = 1; cfg_we = 0; q.push_back(32'hA000_0000);
      for (i = 0; i < 300 && sys_nrst !== 1'b1; i++) tick;
      chk(sys_nrst, 1);
      chk(i < 10 || !s, 1);
      if (!s) chk(osc_stable, 1);
      chk(crystal_mode, !s);
      chk({pll_en, clk_div, clk_gate}, 14'h00FF);
      repeat (3) tick;
      $display("boot test done, strap %0d", s);
   end endtask
   // Back to back fetches and clock settings from the random source
   task run; begin
      cpu_req = 1; cfg_we = 1;
      for (k = 0; k < 8; k++) begin
         r = lfsr(r);
         cpu_vaddr = {3'b101, r[28:0]};
         q.push_back(cpu_vaddr);
         {cfg_pll_en, cfg_div, cfg_gate} = r[31:18];
         tick;
         chk({pll_en, clk_div, clk_gate}, r[31:18]);
      end
      cpu_req = 0; cfg_we = 0;
      repeat (3) tick;
      chk(q.size(), 0);
      $display("fetch test done");
   end endtask
   // Each fetch seen must match the oldest expected address
   always @(negedge clk) begin
      // Decode of the previous fetch stands one cycle later
      if (last_v) begin
         chk(phys_addr, last_va & 32'h1FFF_FFFF);
         chk({uncached, untranslated, boot_chip_select}, {2'b11, last_va[28:26] == 3'b000});
      end
      last_v = (mem_req === 1'b1);
      last_va = fetch_vaddr;
      if (mem_req === 1'b1) begin
         if (q.size() > 0) chk(fetch_vaddr, q.pop_front());
         else chk(0, 1);
      end
   end
   // Main sequence, three resets with strap 1, 0, 1, each followed by a run
   initial begin
      #1;
      boot(1); run; boot(0); run; boot(1); run;
      report_and_stop;
   end
   // Watchdog
   initial begin #200000; n_fail++; report_and_stop; end
endmodule // testbench
bind brs_sequencer brs_checker brs_checker_i (.*);
